// file: tb_top.sv
// Testbench for the repeating-key cipher.
// Assumes the user model drives every press.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import xrk_pkg::*;
  logic       ref_clk;            // Clock
  logic       rst_b;              // Reset, low
  logic       ct_ready;           // Drain side
  logic       load_stb;           // From user
  logic       enc_stb;            // From user
  logic [7:0] pin_in;             // From user
  logic [7:0] pin_out;            // Outputs
  logic       key_ready;          // Key loaded
  logic       enc_ready;          // Room left
  logic [7:0] ct_data;            // Ciphertext
  logic       ct_valid;           // Present
  logic [7:0] key [8];            // Key bytes
  logic [7:0] got [$];            // Drained bytes
  int         failures = 0;
  int         checks   = 0;
  xrk_user u_xrk_user (.ref_clk(ref_clk), .load_stb(load_stb), .enc_stb(enc_stb),
    .pin_in(pin_in));
  xrk_cipher u_xrk_cipher (.ref_clk(ref_clk), .rst_b(rst_b), .load_stb(load_stb),
    .enc_stb(enc_stb), .pin_in(pin_in), .pin_out(pin_out), .key_ready(key_ready),
    .enc_ready(enc_ready), .ct_data(ct_data), .ct_valid(ct_valid), .ct_ready(ct_ready));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bounded drain; a short count ends the run
  task automatic drain(input int cnt);
    got.delete();
    ct_ready = 1'b1;
    for (int t = 0; t < 60 && got.size() < cnt; t++) begin
      if (ct_valid === 1'b1) got.push_back(ct_data);
      @(negedge ref_clk);
    end
    ct_ready = 1'b0;
    check(8'(got.size()), 8'(cnt), "drained");
    if (got.size() != cnt) summarize();
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_clear();
    for (int i = 0; i < 9; i++) u_xrk_user.press(1'b1, XRK_ZERO);
    check({6'h00, pin_out[7:6]}, 8'h02, "flags");
    check({7'h00, key_ready}, 8'h00, "key_ready");
    u_xrk_user.press(1'b0, 8'h5a);
    repeat (3) @(negedge ref_clk);
    check({7'h00, ct_valid}, 8'h00, "ct_valid");
  endtask
  task automatic t_load();
    u_xrk_user.press(1'b1, XRK_ONES);
    for (int i = 0; i < 8; i++) begin
      check({7'h00, key_ready}, 8'h00, "key_ready");
      u_xrk_user.press(1'b1, key[i]);
    end
    check({6'h00, pin_out[7:6]}, 8'h01, "flags");
    check({7'h00, key_ready}, 8'h01, "key_ready");
  endtask
  // Nine bytes fill buffer and output stage, then wrap the key
  task automatic t_stream();
    for (int i = 0; i < 9; i++) u_xrk_user.press(1'b0, 8'ha0 + 8'(i));
    check({7'h00, enc_ready}, 8'h00, "enc_ready");
    u_xrk_user.press(1'b0, 8'h5a);
    drain(9);
    for (int i = 0; i < 9; i++) check(got[i], (8'ha0 + 8'(i)) ^ key[i % 8], "ct");
    check({2'h0, pin_out[5:0]}, {2'h0, 6'h1a ^ key[1][5:0]}, "xor bits");
    u_xrk_user.press(1'b0, 8'hc3);
    drain(1);
    check(got[0], 8'hc3 ^ key[1], "ct");
  endtask
  // ==========================================================
  // Clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    rst_b    = 1'b0;
    ct_ready = 1'b0;
    for (int i = 0; i < 8; i++) key[i] = 8'h11 * 8'(i + 1);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    check(pin_out, 8'h80, "pin_out");
    check({5'h00, key_ready, enc_ready, ct_valid}, 8'h02, "status");
    t_clear();
    t_load();
    t_stream();
    // Clearing a loaded key must bring the zero head back
    t_clear();
    summarize();
  end
endmodule : tb_top
`default_nettype wire

// file: xrk_cipher.sv
// ==========================================================
// Eight-byte repeating-key XOR cipher with a buffered ciphertext port.
// Assumes key-load and encrypt strobes are one-cycle pulses already
// debounced and synchronous to ref_clk.
//
// What this block does
// - Eight-byte key shift register, load press shifts
// - All-ones head byte marks load complete
// - Loaded key: low six outputs are input XOR key
// - Key bytes rotate, repeating every eight bytes
// - Zero head drives seventh output low
// - Ones head drives eighth output low
// - One byte per encrypt press, key advances
// - Flags: head not zero, head not ones
`timescale 1ns/1ps
`default_nettype none
module xrk_cipher (
  input  wire logic       ref_clk,    // 50 MHz clock
  input  wire logic       rst_b,      // Async reset, active low
  input  wire logic       load_stb,   // Key-load press, one-cycle pulse
  input  wire logic       enc_stb,    // Encrypt press, one-cycle pulse
  input  wire logic [7:0] pin_in,     // Key or message byte
  output logic      [7:0] pin_out,    // XOR bits and head flags
  output logic            key_ready,  // Head holds the load marker
  output logic            enc_ready,  // Buffer can take a byte
  output logic      [7:0] ct_data,    // Buffered ciphertext
  output logic            ct_valid,   // Ciphertext present
  input  wire logic       ct_ready    // Consumer takes ciphertext
);
  import xrk_pkg::*;

  // ==========================================================
  // State
  logic [7:0] head_reg, head_next;
  logic [7:0] key_reg  [XRK_KEY_DEPTH];
  logic [7:0] key_next [XRK_KEY_DEPTH];
  logic [2:0] idx_reg, idx_next;
  logic [7:0] pin_reg, pin_next;
  logic       rdy_reg, rdy_next;
  logic [7:0] ct_reg, ct_next;
  logic       ctv_reg, ctv_next;
  logic [7:0] cur_key;
  logic [7:0] cipher;
  logic       enc_take;
  logic [3:0] occ_reg, occ_next;
  logic       room_reg, room_next;
  logic       drain_pop;

  xrk_stream_if #(.W(XRK_BYTE_W)) fill_if ();
  xrk_stream_if #(.W(XRK_BYTE_W)) drain_if ();

  // ==========================================================
  // Key shift register
  // The head sits past the eight key entries, so the marker byte arrives
  // there exactly when the eighth key byte has been shifted in.
  always_comb begin
    head_next = head_reg;
    if (load_stb) begin
      head_next = key_reg[XRK_KEY_DEPTH-1];
    end
  end

  // One generate loop for every key entry; entry 0 takes the pins
  for (genvar g = 0; g < XRK_KEY_DEPTH; g++) begin : g_key
    always_comb begin
      key_next[g] = key_reg[g];
      if (load_stb) begin
        key_next[g] = (g == 0) ? pin_in : key_reg[(g == 0) ? 0 : g - 1];
      end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        key_reg[g] <= XRK_ZERO;
      end else begin
        key_reg[g] <= key_next[g];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      head_reg <= XRK_ZERO;
    end else begin
      head_reg <= head_next;
    end
  end

  // ==========================================================
  // Key position and encrypt acceptance
  // A load press wins over a same-cycle encrypt press and restarts the
  // key sequence. An encrypt press while the key is not loaded, or while
  // the buffer is full, is dropped and does not advance the key.
  assign enc_take = enc_stb && !load_stb && rdy_reg && fill_if.ready;

  // The first key byte loaded ends in the deepest entry
  assign cur_key  = key_reg[XRK_IDX_LAST - idx_reg];
  assign cipher   = pin_in ^ cur_key;

  always_comb begin
    idx_next = idx_reg;
    if (load_stb) begin
      idx_next = XRK_IDX_FIRST;
    end else if (enc_take) begin
      idx_next = idx_reg + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_reg <= XRK_IDX_FIRST;
    end else begin
      idx_reg <= idx_next;
    end
  end

  // ==========================================================
  // Pin outputs
  // Registered copy of the live XOR so every output is a flop; it lags
  // the pins by one cycle, which is invisible at switch speeds.
  always_comb begin
    pin_next                            = pin_reg;
    pin_next[XRK_PIN_NZ-1:0]            = cipher[XRK_PIN_NZ-1:0];
    pin_next[XRK_PIN_NZ]                = (head_next != XRK_ZERO);
    pin_next[XRK_PIN_NO]                = (head_next != XRK_ONES);
    rdy_next                            = (head_next == XRK_ONES);
  end

  // Reset shows an unloaded key: the head reads zero, so it is not all ones
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_reg <= XRK_PIN_RST;
      rdy_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
      rdy_reg <= rdy_next;
    end
  end

  // ==========================================================
  // Ciphertext buffer
  // The buffer absorbs bursts of presses while the consumer stalls;
  // once full, enc_ready drops and further presses are refused.
  assign fill_if.data  = cipher;
  assign fill_if.valid = enc_take;

  xrk_fifo #(
    .WIDTH (XRK_BYTE_W),
    .DEPTH (XRK_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .in_if   (fill_if),
    .out_if  (drain_if)
  );

  // Output stage so the ciphertext port is driven from flops
  assign drain_if.ready = !ctv_reg || ct_ready;

  always_comb begin
    ct_next  = ct_reg;
    ctv_next = ctv_reg;
    if (drain_if.ready) begin
      ctv_next = drain_if.valid;
      if (drain_if.valid) begin
        ct_next = drain_if.data;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ct_reg  <= XRK_ZERO;
      ctv_reg <= 1'b0;
    end else begin
      ct_reg  <= ct_next;
      ctv_reg <= ctv_next;
    end
  end

  // ==========================================================
  // Registered room flag
  // A private copy of the buffer's fill count lets enc_ready leave a flop
  // rather than a compare on another module's register. It counts the
  // same push and pop events as the buffer, so both agree every cycle;
  // the buffer's own ready alone gates writes, so a drift here could only
  // skew enc_ready, never refuse presses or overfill the buffer.
  assign drain_pop = drain_if.valid && drain_if.ready;

  always_comb begin
    occ_next = occ_reg;
    if (enc_take && !drain_pop) begin
      occ_next = occ_reg + 4'h1;
    end else if (drain_pop && !enc_take) begin
      occ_next = occ_reg - 4'h1;
    end
    room_next = (occ_next != 4'(XRK_FIFO_DEPTH));
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      occ_reg  <= 4'h0;
      room_reg <= 1'b1;
    end else begin
      occ_reg  <= occ_next;
      room_reg <= room_next;
    end
  end

  // ==========================================================
  // Outputs
  // Every port below is a register; the pin copy lags the switches by
  // one cycle, which nobody at the buttons can see.
  assign pin_out   = pin_reg;
  assign key_ready = rdy_reg;
  assign enc_ready = room_reg;        // Mirrored buffer room
  assign ct_data   = ct_reg;
  assign ct_valid  = ctv_reg;
endmodule : xrk_cipher
`default_nettype wire

// file: xrk_cipher_props.sv
// Port checker for the repeating-key cipher.
// Assumes one clock domain and the bind below.
`timescale 1ns/1ps
`default_nettype none
module xrk_cipher_props (
  input wire logic       ref_clk,   // Clock
  input wire logic       rst_b,     // Reset, low
  input wire logic       load_stb,  // Load press
  input wire logic       enc_stb,   // Encrypt press
  input wire logic [7:0] pin_in,    // Switches
  input wire logic [7:0] pin_out,   // Outputs
  input wire logic       key_ready, // Key loaded
  input wire logic       enc_ready, // Room left
  input wire logic [7:0] ct_data,   // Ciphertext
  input wire logic       ct_valid,  // Present
  input wire logic       ct_ready   // Taken
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // An encrypt press the block must take
  sequence enc_take;
    enc_stb && !load_stb && key_ready && enc_ready;
  endsequence
  AST_FLAG_PAIR: assert property (key_ready == !pin_out[7])
    else $error("key ready and ones flag disagree");
  AST_READY_NZ: assert property (key_ready |-> pin_out[6])
    else $error("ready head shown as zero");
  AST_KEY_STILL: assert property (!load_stb |=> $stable(pin_out[7:6]))
    else $error("head flags moved without a load press");
  AST_READY_STILL: assert property (!load_stb |=> $stable(key_ready))
    else $error("key ready moved without a load press");
  AST_CT_HOLD: assert property (ct_valid && !ct_ready |=> ct_valid && $stable(ct_data))
    else $error("ciphertext dropped before taken");
  AST_ENC_ACCEPT: assert property (enc_take and !ct_valid |-> ##[1:2] ct_valid)
    else $error("accepted byte never appeared");
  AST_FULL_CAUSE: assert property ($fell(enc_ready) |-> $past(enc_stb && key_ready))
    else $error("buffer filled without an encrypt");
  AST_RESET_VAL: assert property (!$past(rst_b) |-> pin_out[7:6] == 2'h2 && !ct_valid)
    else $error("wrong flags after reset");
endmodule : xrk_cipher_props
bind xrk_cipher xrk_cipher_props u_xrk_cipher_props (.ref_clk, .rst_b, .load_stb, .enc_stb,
  .pin_in, .pin_out, .key_ready, .enc_ready, .ct_data, .ct_valid, .ct_ready);
`default_nettype wire

// file: xrk_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module xrk_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic ref_clk,  // Clock
  input  wire logic rst_b,    // Async reset, active low
  xrk_stream_if.snk in_if,    // Fill side
  xrk_stream_if.src out_if    // Drain side
);
  import xrk_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next;
  logic [AW-1:0]    rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // ==========================================================
  // Handshake; ready and valid come straight from the count register
  assign in_if.ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_if.valid = (cnt_reg != '0);
  assign out_if.data  = mem[rd_reg];
  assign push         = in_if.valid && in_if.ready;
  assign pop          = out_if.valid && out_if.ready;

  // Pointer wrap works for any depth, not only powers of two
  always_comb begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; a word is only read after it was written
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_reg] <= in_if.data;
    end
  end
endmodule : xrk_fifo
`default_nettype wire

// file: xrk_pkg.sv
// Constants shared by the repeating-key cipher and its output FIFO.
// Assumes one 50 MHz clock domain and byte-wide data everywhere.
package xrk_pkg;
  // ==========================================================
  // Widths and depths
  localparam int          XRK_BYTE_W     = 8;
  localparam int          XRK_KEY_DEPTH  = 8;
  localparam int          XRK_IDX_W      = 3;
  localparam int          XRK_FIFO_DEPTH = 8;
  // ==========================================================
  // Key byte values and pin positions
  localparam logic [7:0]  XRK_ONES       = 8'hff;  // Load-complete marker
  localparam logic [7:0]  XRK_ZERO       = 8'h00;  // Value after reset
  localparam logic [7:0]  XRK_PIN_RST    = 8'h80;  // Pins after reset: head zero, not all ones
  localparam logic [2:0]  XRK_IDX_FIRST  = 3'h0;   // Position after a load press
  localparam logic [2:0]  XRK_IDX_LAST   = 3'h7;   // Deepest key entry
  localparam int          XRK_PIN_NZ     = 6;      // Head byte is not zero
  localparam int          XRK_PIN_NO     = 7;      // Head byte is not all ones
  // ==========================================================
  // Clock
  localparam int          XRK_CLK_NS     = 20;
  localparam int          XRK_PIPE_CYC   = 1;      // Strobe to registered output
endpackage : xrk_pkg

// file: xrk_stream_if.sv
// Valid/ready byte stream between the cipher core and its FIFO.
// Assumes both ends share one clock; the interface carries no clock.
`timescale 1ns/1ps
`default_nettype none
interface xrk_stream_if #(parameter int W = 8);
  logic [W-1:0] data;   // Payload
  logic         valid;  // Source holds data
  logic         ready;  // Sink can take data
  // ==========================================================
  // Views
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : xrk_stream_if
`default_nettype wire

// file: xrk_user.sv
// Model of the person at the switches and the two buttons.
// Assumes presses arrive already debounced, one cycle long.
`timescale 1ns/1ps
`default_nettype none
module xrk_user (
  input  wire logic       ref_clk,   // Clock
  output logic            load_stb,  // Load press
  output logic            enc_stb,   // Encrypt press
  output logic      [7:0] pin_in     // Switches
);
  // ==========================================================
  // Idle switches and buttons
  initial begin
    load_stb = 1'b0;
    enc_stb  = 1'b0;
    pin_in   = 8'h00;
  end
  // Switches stay set after the press, as real ones do
  task automatic press(input logic ld, input logic [7:0] val);
    @(negedge ref_clk);
    pin_in   = val;
    load_stb = ld;
    enc_stb  = !ld;
    @(negedge ref_clk);
    load_stb = 1'b0;
    enc_stb  = 1'b0;
  endtask
endmodule : xrk_user
`default_nettype wire
